// [oitmp_octet_port.sv]
// Indirect access port of one octet: pointer, silo alarm setting, transmit silos, modem status
// Function
// - Each alarm setting step adds about one millisecond; timing may be coarse.
// - Master reset or bus init sets the alarm setting to one.
// - Each octet offers thirty-two indirect registers through one shared window.
// - Pointer bits 2:0 pick the line, bits 4:3 pick its indirect register.
// - The window sits at byte offset six; reads and writes differ there.
// - A word write to register zero queues low byte then high byte.
// - A byte write to register zero queues the low byte only.
// - Writes to register zero queue even in DMA mode; software should avoid it.
// - Register zero reads modem inputs in 15:8, refreshed at reset without posting.
// - A modem change stays pending while the receive silo is full.
// - Bits 15..12 carry data set ready, ring, carrier, clear to send.
// - Bit 10 carries the line's user receive input.
// - Bits 7:0 give the transmit silo fill; reset clears it.
// - Alarm fires after data waits the timeout; reads and resets restart it.
// - Setting spans to about 255 ms; zero disables the alarm.
// - Writing register zero clears the line's pre-empt bit.
`include "oitmp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module oitmp_octet_port #(
  parameter int unsigned MS_CYCLES = `OITMP_MS_NS / `OITMP_CLK_NS
) (
  // Clock and resets
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic bus_init_in,
  // Register bus
  input wire oitmp_pkg::oitmp_bus_req_t bus_req_in,
  output logic [15:0] rdata_out,
  output logic rdata_valid_out,
  output logic busy_out,
  // Transmit silo drain, one lane per line
  input wire logic [7:0] tx_ready_in,
  output logic [7:0] tx_valid_out,
  output logic [63:0] tx_data_out,
  output logic [7:0] preempt_out,
  // Modem inputs and change reporting
  input wire oitmp_pkg::oitmp_modem_t [7:0] modem_in,
  input wire logic [7:0] change_enable_in,
  input wire logic rx_full_in,
  output logic change_post_out,
  output logic [2:0] change_line_out,
  // Receive silo alarm
  input wire logic rx_read_in,
  input wire logic rx_nonempty_in,
  output logic rx_alarm_out
);
  localparam int CW = $clog2(`OITMP_TX_DEPTH + 1);

  function automatic logic [7:0] line_mask(input logic [2:0] line);
    line_mask = 8'h01 << line;
  endfunction

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    lowest_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = 3'(i);
      end
    end
  endfunction

  function automatic logic [7:0] modem_byte(input oitmp_pkg::oitmp_modem_t m);
    modem_byte = {m.dsr, m.ri, m.cd, m.cts, 1'b0, m.user, 2'b00};
  endfunction

  oitmp_pkg::oitmp_state_t state;
  logic [4:0] pointer;
  logic [7:0] alarm_setting;
  logic [7:0] hold_high;
  logic [2:0] hold_line;
  logic primed;
  logic [7:0] pending;
  oitmp_pkg::oitmp_modem_t [7:0] modem_q;
  logic [7:0] fifo_ready;
  logic [CW-1:0] fifo_count [8];

  // Bus decode
  wire logic idle = state == oitmp_pkg::OITMP_S_IDLE;
  wire logic wr_ok = bus_req_in.wr && idle;
  wire logic [2:0] sel_line = pointer[2:0];
  wire logic [1:0] sel_reg = pointer[4:3];
  wire logic hit_window = bus_req_in.addr == `OITMP_OFF_WINDOW;
  wire logic wr_csr = wr_ok && bus_req_in.addr == `OITMP_OFF_CSR;
  wire logic wr_rsp = wr_ok && bus_req_in.addr == `OITMP_OFF_RSP;
  wire logic wr_tx = wr_ok && hit_window && sel_reg == `OITMP_REG_TXCHAR;
  wire logic wr_lc = wr_ok && hit_window && sel_reg == `OITMP_REG_LINECTL;
  wire logic wr_tx_word = wr_tx && !bus_req_in.byte_wr;
  wire logic wr_tx_byte = wr_tx && bus_req_in.byte_wr;

  // Character push: low byte at once, high byte next cycle
  wire logic high_phase = state == oitmp_pkg::OITMP_S_HIGH;
  wire logic push_req = wr_tx || high_phase;
  wire logic [7:0] push_char = high_phase ? hold_high : bus_req_in.data[7:0];
  wire logic [2:0] push_line = high_phase ? hold_line : sel_line;
  wire logic [7:0] push_valid = push_req ? line_mask(push_line) : 8'h00;
  wire oitmp_pkg::oitmp_state_t next_state = wr_tx_word ? oitmp_pkg::OITMP_S_HIGH : oitmp_pkg::OITMP_S_IDLE;

  // Pre-empt bits
  wire logic [7:0] sel_mask = line_mask(sel_line);
  wire logic [7:0] preempt_set = bus_req_in.data[`OITMP_PREEMPT_BIT] ? sel_mask : 8'h00;
  wire logic [7:0] next_preempt = wr_lc ? ((preempt_out & ~sel_mask) | preempt_set)
                                : wr_tx ? (preempt_out & ~sel_mask)
                                : preempt_out;

  // Modem change detection and posting
  logic [7:0] changed;
  always_comb begin
    changed = 8'h00;
    for (int i = 0; i < 8; i++) begin
      changed[i] = primed && (modem_q[i] != modem_in[i]);
    end
  end
  wire logic [7:0] pend_set = changed & change_enable_in;
  wire logic post_now = !rx_full_in && pending != 8'h00;
  wire logic [2:0] post_line = lowest_set(pending);
  wire logic [7:0] pend_clr = post_now ? line_mask(post_line) : 8'h00;
  wire logic [7:0] next_pending = (pending & ~pend_clr) | pend_set;

  // Read data
  wire logic [7:0] sel_count = 8'(fifo_count[sel_line]);
  wire logic [15:0] window_word = {modem_byte(modem_q[sel_line]), sel_count};
  wire logic [15:0] window_read = sel_reg == `OITMP_REG_TXCHAR ? window_word : 16'h0000;
  wire logic [15:0] next_rdata = hit_window ? window_read
                               : bus_req_in.addr == `OITMP_OFF_CSR ? {11'h000, pointer}
                               : 16'h0000;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= oitmp_pkg::OITMP_S_IDLE;
      pointer <= `OITMP_PTR_RESET;
      alarm_setting <= `OITMP_ALARM_RESET;
      preempt_out <= 8'h00;
      busy_out <= 1'b0;
    end else if (bus_init_in) begin
      state <= oitmp_pkg::OITMP_S_IDLE;
      pointer <= `OITMP_PTR_RESET;
      alarm_setting <= `OITMP_ALARM_RESET;
      preempt_out <= 8'h00;
      busy_out <= 1'b0;
    end else begin
      case (state)
        oitmp_pkg::OITMP_S_IDLE: state <= next_state;
        oitmp_pkg::OITMP_S_HIGH: state <= oitmp_pkg::OITMP_S_IDLE;
        default: state <= oitmp_pkg::OITMP_S_IDLE;
      endcase
      pointer <= wr_csr ? bus_req_in.data[4:0] : pointer;
      alarm_setting <= wr_rsp ? bus_req_in.data[7:0] : alarm_setting;
      preempt_out <= next_preempt;
      busy_out <= wr_tx_word;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_high <= 8'h00;
      hold_line <= 3'h0;
      rdata_out <= 16'h0000;
      rdata_valid_out <= 1'b0;
    end else begin
      hold_high <= wr_tx_word ? bus_req_in.data[15:8] : hold_high;
      hold_line <= wr_tx ? sel_line : hold_line;
      rdata_out <= bus_req_in.rd ? next_rdata : rdata_out;
      rdata_valid_out <= bus_req_in.rd;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      primed <= 1'b0;
      modem_q <= '0;
      pending <= 8'h00;
      change_post_out <= 1'b0;
      change_line_out <= 3'h0;
    end else if (bus_init_in) begin
      primed <= 1'b0;
      pending <= 8'h00;
      change_post_out <= 1'b0;
    end else begin
      primed <= 1'b1;
      modem_q <= modem_in;
      pending <= next_pending;
      change_post_out <= post_now;
      change_line_out <= post_now ? post_line : change_line_out;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_line
    oitmp_tx_fifo #(
      .WIDTH(8),
      .DEPTH(`OITMP_TX_DEPTH)
    ) u_silo (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .clear_in(bus_init_in),
      .in_valid_in(push_valid[i]),
      .in_data_in(push_char),
      .in_ready_out(fifo_ready[i]),
      .out_valid_out(tx_valid_out[i]),
      .out_data_out(tx_data_out[i*8 +: 8]),
      .out_ready_in(tx_ready_in[i]),
      .count_out(fifo_count[i])
    );
  end

  oitmp_alarm_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_alarm (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(bus_init_in),
    .setting_in(alarm_setting),
    .nonempty_in(rx_nonempty_in),
    .read_in(rx_read_in),
    .alarm_out(rx_alarm_out)
  );

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in || bus_init_in);

  sequence s_word_write;
    wr_tx_word;
  endsequence

  sequence s_high_push(logic [7:0] hi);
    high_phase && push_req && push_char == hi;
  endsequence

  property p_low_then_high;
    logic [7:0] hi;
    (s_word_write, hi = bus_req_in.data[15:8]) |-> push_char == bus_req_in.data[7:0] ##1 s_high_push(hi);
  endproperty

  a_word_low_first: assert property (p_low_then_high)
    else $error("word write did not queue low then high byte");
  a_byte_single_push: assert property (wr_tx_byte |=> idle && !busy_out)
    else $error("byte write queued more than one character");
  a_pointer_line_select: assert property (wr_tx |-> push_valid == line_mask(pointer[2:0]))
    else $error("push went to a line other than the pointer's");
  a_fill_count_read: assert property (bus_req_in.rd && hit_window && sel_reg == 2'h0
                                      |=> rdata_valid_out && rdata_out[7:0] == $past(sel_count))
    else $error("window read returned the wrong fill count");
  a_modem_byte_map: assert property (bus_req_in.rd && hit_window && sel_reg == 2'h0
                                     |=> rdata_out[15:8] == {$past(modem_q[sel_line].dsr), $past(modem_q[sel_line].ri),
                                                             $past(modem_q[sel_line].cd), $past(modem_q[sel_line].cts),
                                                             1'b0, $past(modem_q[sel_line].user), 2'b00})
    else $error("modem status byte mapped wrongly");
  a_preempt_cleared: assert property (wr_tx |=> !preempt_out[$past(sel_line)])
    else $error("pre-empt bit survived a character write");
  a_full_silo_discard: assert property (push_req && !fifo_ready[push_line]
                                        |=> fifo_count[$past(push_line)] <= $past(fifo_count[push_line]))
    else $error("full silo grew on a discarded character");
  a_change_held_full: assert property (rx_full_in |=> !change_post_out)
    else $error("modem change posted into a full silo");
  a_setting_after_init: assert property ($past(bus_init_in) && !wr_rsp |-> alarm_setting == 8'h01)
    else $error("alarm setting not one after bus init");

  sequence s_quiet_posts;
    !change_post_out ##1 !change_post_out;
  endsequence

  property p_init_clears;
    @(posedge clk_in) disable iff (!resetn_in)
      bus_init_in |=> idle && pointer == `OITMP_PTR_RESET && preempt_out == 8'h00
                      && tx_valid_out == 8'h00 && sel_count == 8'h00;
  endproperty

  property p_init_setting;
    @(posedge clk_in) disable iff (!resetn_in)
      bus_init_in |=> alarm_setting == `OITMP_ALARM_RESET;
  endproperty

  property p_init_quiet;
    @(posedge clk_in) disable iff (!resetn_in)
      bus_init_in |=> s_quiet_posts;
  endproperty

  property p_unused_zero;
    bus_req_in.rd && hit_window && sel_reg != `OITMP_REG_TXCHAR |=> rdata_out == 16'h0000;
  endproperty

  a_init_clears_state: assert property (p_init_clears)
    else $error("bus init left pointer, pre-empt or silo state behind");
  a_init_setting_one: assert property (p_init_setting)
    else $error("alarm setting not one right after bus init");
  a_init_no_post: assert property (p_init_quiet)
    else $error("modem change posted by the refresh after init");
  a_unused_regs_zero: assert property (p_unused_zero)
    else $error("indirect register other than zero read nonzero");
  a_read_answer: assert property (bus_req_in.rd |=> rdata_valid_out)
    else $error("read not answered one cycle later");
  a_valid_one_cycle: assert property (!bus_req_in.rd |=> !rdata_valid_out)
    else $error("read valid without a read");
  a_word_sets_busy: assert property (wr_tx_word |=> busy_out && high_phase)
    else $error("word write did not hold the bus for its high byte");
  a_high_same_line: assert property (wr_tx_word |=> push_valid == $past(sel_mask))
    else $error("high byte went to another line");
  a_fill_capped: assert property (sel_count <= 8'h20)
    else $error("fill count above silo depth");
  a_pending_posts: assert property (!rx_full_in && pending != 8'h00 |=> change_post_out)
    else $error("pending modem change not posted into a nonfull silo");
endmodule
`default_nettype wire

// [oitmp_map.svh]
// Offsets, field positions, reset values and timing counts of the octet port
`ifndef OITMP_MAP_SVH
`define OITMP_MAP_SVH

`define OITMP_OFF_CSR 4'h0
`define OITMP_OFF_RSP 4'h4
`define OITMP_OFF_WINDOW 4'h6
`define OITMP_REG_TXCHAR 2'h0
`define OITMP_REG_LINECTL 2'h1
`define OITMP_PREEMPT_BIT 15
`define OITMP_PTR_RESET 5'h00
`define OITMP_ALARM_RESET 8'h01
`define OITMP_TX_DEPTH 32
`define OITMP_CLK_NS 32'h00000008
`define OITMP_MS_NS 32'h000F4240

`endif

// [oitmp_pkg.sv]
// Types shared by the octet port modules
package oitmp_pkg;

  typedef enum logic [1:0] {
    OITMP_S_IDLE = 2'b01,
    OITMP_S_HIGH = 2'b10
  } oitmp_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_wr;
    logic [3:0] addr;
    logic [15:0] data;
  } oitmp_bus_req_t;

  typedef struct packed {
    logic dsr;
    logic ri;
    logic cd;
    logic cts;
    logic user;
  } oitmp_modem_t;

endpackage

// [oitmp_tx_fifo.sv]
// Transmit silo of one line, with a registered head stage
`timescale 1ns/1ps
`default_nettype none
module oitmp_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] mem_cnt;

  wire logic push = in_valid_in && in_ready_out;
  wire logic pop = out_valid_out && out_ready_in;
  wire logic load = (mem_cnt != '0) && (!out_valid_out || pop);
  wire logic [CW-1:0] next_mem_cnt = mem_cnt + CW'(push) - CW'(load);
  wire logic [CW-1:0] next_count = count_out + CW'(push) - CW'(pop);

  assign in_ready_out = count_out < CW'(DEPTH);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_cnt <= '0;
      count_out <= '0;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (clear_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_cnt <= '0;
      count_out <= '0;
      out_valid_out <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(load);
      mem_cnt <= next_mem_cnt;
      count_out <= next_count;
      out_valid_out <= load || (out_valid_out && !pop);
      if (load) begin
        out_data_out <= mem[rd_ptr];
      end
    end
  end
endmodule
`default_nettype wire

// [oitmp_alarm_timer.sv]
// Receive silo alarm timer in coarse millisecond steps
`timescale 1ns/1ps
`default_nettype none
module oitmp_alarm_timer #(
  parameter int unsigned MS_CYCLES = 125000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  // Setting and receive silo state
  input wire logic [7:0] setting_in,
  input wire logic nonempty_in,
  input wire logic read_in,
  // Alarm pulse
  output logic alarm_out
);
  localparam int TW = $clog2(MS_CYCLES + 1);

  logic [TW-1:0] tick;
  logic [7:0] ms;
  logic fired;

  wire logic restart = clear_in || read_in || !nonempty_in;
  wire logic tick_wrap = tick == TW'(MS_CYCLES - 1);
  wire logic [TW-1:0] next_tick = tick_wrap ? '0 : tick + TW'(1);
  wire logic [7:0] next_ms = (tick_wrap && ms != 8'hFF) ? ms + 8'h01 : ms;
  wire logic due = (setting_in != 8'h00) && (ms >= setting_in) && !fired;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick <= '0;
      ms <= 8'h00;
      fired <= 1'b0;
      alarm_out <= 1'b0;
    end else if (restart) begin
      tick <= '0;
      ms <= 8'h00;
      fired <= 1'b0;
      alarm_out <= 1'b0;
    end else begin
      tick <= next_tick;
      ms <= next_ms;
      fired <= fired || due;
      alarm_out <= due;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_alarm_zero_off: assert property (setting_in == 8'h00 |=> !alarm_out)
    else $error("alarm raised with a zero setting");
  a_alarm_restart_quiet: assert property (restart |=> !alarm_out)
    else $error("alarm raised right after a restart");
  a_alarm_after_delay: assert property (alarm_out |-> $past(ms) >= $past(setting_in))
    else $error("alarm raised before the delay ran out");
endmodule
`default_nettype wire

// [oitmp_host_model.sv]
// Host bus model driving write and read cycles into the octet port
`timescale 1ns/1ps
`default_nettype none
module oitmp_host_model (
  // Clock
  input wire logic clk_in,
  // Register bus
  output var oitmp_pkg::oitmp_bus_req_t req_out,
  input wire logic [15:0] rdata_in,
  input wire logic rdata_valid_in
);
  initial req_out = '{rd: 1'b0, wr: 1'b0, byte_wr: 1'b0, addr: 4'hF, data: 16'h5A5A};
  // One write cycle, released bus shows inverted values, extra idle cycle after a word
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic b);
    @(negedge clk_in);
    req_out.addr = a;
    req_out.data = d;
    req_out.byte_wr = b;
    req_out.wr = 1'b1;
    @(negedge clk_in);
    req_out.wr = 1'b0;
    req_out.addr = ~a;
    req_out.data = ~d;
    if (!b) @(negedge clk_in);
  endtask
  // Reads and writes are separate cycles, never combined
  task automatic rd(input logic [3:0] a, output logic v, output logic [15:0] q);
    @(negedge clk_in);
    req_out.addr = a;
    req_out.rd = 1'b1;
    @(negedge clk_in);
    req_out.rd = 1'b0;
    req_out.addr = ~a;
    v = rdata_valid_in;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the octet indirect port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [4:0] ptr;
    oitmp_pkg::oitmp_modem_t mdm;
    logic [15:0] exp;
  } oitmp_row_t;
  localparam int MS = 8;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic bus_init = 1'b0;
  oitmp_pkg::oitmp_bus_req_t req;
  logic [15:0] rdata;
  logic rvalid, busy, post, alarm;
  logic [7:0] tx_ready = 8'h00;
  logic [7:0] tx_valid, preempt;
  logic [63:0] tx_data;
  oitmp_pkg::oitmp_modem_t [7:0] modem = '0;
  logic [7:0] chg_en = 8'h00;
  logic rx_full = 1'b0;
  logic rx_read = 1'b0;
  logic rx_nonempty = 1'b0;
  logic [2:0] pline;
  int n_fail = 0;
  int checks_done = 0;
  int n, k;
  logic v;
  logic [15:0] q;
  logic [7:0] drain_exp [3] = '{8'hA1, 8'hB2, 8'hC3};
  oitmp_row_t rows [11] = '{
    '{5'h00, 5'h10, 16'h8000}, '{5'h01, 5'h08, 16'h4000}, '{5'h02, 5'h04, 16'h2000},
    '{5'h03, 5'h02, 16'h1000}, '{5'h04, 5'h01, 16'h0400}, '{5'h05, 5'h1F, 16'hF400},
    '{5'h06, 5'h15, 16'hA400}, '{5'h07, 5'h00, 16'h0000}, '{5'h08, 5'h10, 16'h0000},
    '{5'h10, 5'h10, 16'h0000}, '{5'h18, 5'h10, 16'h0000}};

  always #4 clk_in = ~clk_in;

  oitmp_octet_port #(.MS_CYCLES(MS)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .bus_init_in(bus_init), .bus_req_in(req),
    .rdata_out(rdata), .rdata_valid_out(rvalid), .busy_out(busy), .tx_ready_in(tx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .preempt_out(preempt), .modem_in(modem),
    .change_enable_in(chg_en), .rx_full_in(rx_full), .change_post_out(post),
    .change_line_out(pline), .rx_read_in(rx_read), .rx_nonempty_in(rx_nonempty),
    .rx_alarm_out(alarm));

  oitmp_host_model host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .rdata_valid_in(rvalid));

  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("MISMATCH at %0t: count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // Set pointer, read the window, compare valid and data
  task automatic rdw(input logic [4:0] p, input logic [15:0] e);
    host.wr(4'h0, {11'h000, p}, 1'b0);
    host.rd(4'h6, v, q);
    chk({15'h0000, v}, 16'h0001);
    chk(q, e);
  endtask
  task automatic wait_alarm(input int lim, input logic must, output int c);
    c = 0;
    while (alarm !== 1'b1 && c < lim) begin
      @(negedge clk_in);
      c++;
    end
    if (must && c == lim) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic count_posts(input int cyc, output int p);
    p = 0;
    repeat (cyc) begin
      @(negedge clk_in);
      if (post === 1'b1) p++;
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    @(negedge clk_in);
    rx_nonempty = 1'b1;
    wait_alarm(10 * MS, 1'b1, n);
    chk_rng(n, MS - 2, MS + 4);
    rx_nonempty = 1'b0;
    foreach (rows[i]) begin
      @(negedge clk_in);
      modem[rows[i].ptr[2:0]] = rows[i].mdm;
      rdw(rows[i].ptr, rows[i].exp);
    end
    host.wr(4'h0, 16'h0002, 1'b0);
    fork
      host.wr(4'h6, 16'hB2A1, 1'b0);
      begin
        repeat (2) @(negedge clk_in);
        chk({15'h0000, busy}, 16'h0001);
      end
    join
    host.wr(4'h6, 16'hFFC3, 1'b1);
    rdw(5'h02, 16'h2003);
    for (int i = 0; i < 3; i++) begin
      chk({15'h0000, tx_valid[2]}, 16'h0001);
      chk({8'h00, tx_data[23:16]}, {8'h00, drain_exp[i]});
      tx_ready[2] = 1'b1;
      @(negedge clk_in);
      tx_ready[2] = 1'b0;
      @(negedge clk_in);
    end
    chk({15'h0000, tx_valid[2]}, 16'h0000);
    for (int i = 0; i < 33; i++) host.wr(4'h6, {8'hEE, i[7:0]}, 1'b1);
    rdw(5'h02, 16'h2020);
    tx_ready[2] = 1'b1;
    k = 0;
    n = 0;
    while (tx_valid[2] !== 1'b0 && n < 40) begin
      @(negedge clk_in);
      n++;
      k++;
    end
    chk_rng(k, 32, 32);
    rdw(5'h02, 16'h2000);
    host.wr(4'h0, 16'h000A, 1'b0);
    host.wr(4'h6, 16'h8000, 1'b0);
    chk({15'h0000, preempt[2]}, 16'h0001);
    host.wr(4'h0, 16'h0002, 1'b0);
    host.wr(4'h6, 16'h0055, 1'b1);
    chk({15'h0000, preempt[2]}, 16'h0000);
    host.rd(4'h2, v, q);
    chk(q, 16'h0000);
    host.wr(4'h4, 16'h0003, 1'b0);
    rx_nonempty = 1'b1;
    wait_alarm(10 * MS, 1'b1, n);
    chk_rng(n, 3 * MS - 2, 3 * MS + 4);
    rx_nonempty = 1'b0;
    @(negedge clk_in);
    rx_nonempty = 1'b1;
    repeat (2 * MS) @(negedge clk_in);
    rx_read = 1'b1;
    @(negedge clk_in);
    rx_read = 1'b0;
    wait_alarm(10 * MS, 1'b1, n);
    chk_rng(n, 3 * MS - 3, 3 * MS + 4);
    rx_nonempty = 1'b0;
    host.wr(4'h4, 16'h0000, 1'b0);
    rx_nonempty = 1'b1;
    wait_alarm(40 * MS, 1'b0, n);
    chk_rng(n, 40 * MS, 40 * MS);
    rx_nonempty = 1'b0;
    chg_en = 8'h02;
    rx_full = 1'b1;
    modem[1].cd = 1'b1;
    count_posts(12, n);
    chk_rng(n, 0, 0);
    rx_full = 1'b0;
    n = 0;
    while (post !== 1'b1 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    chk_rng(n, 0, 9);
    chk({13'h0000, pline}, 16'h0001);
    tx_ready[1] = 1'b0;
    host.wr(4'h0, 16'h0001, 1'b0);
    host.wr(4'h6, 16'h0077, 1'b1);
    rx_full = 1'b1;
    modem[1].cts = 1'b1;
    repeat (2) @(negedge clk_in);
    bus_init = 1'b1;
    @(negedge clk_in);
    bus_init = 1'b0;
    rx_full = 1'b0;
    count_posts(12, n);
    chk_rng(n, 0, 0);
    rdw(5'h01, 16'h7000);
    rx_nonempty = 1'b1;
    wait_alarm(10 * MS, 1'b1, n);
    chk_rng(n, MS - 2, MS + 4);
    rx_nonempty = 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
